/* File: dv/cxc_core_asserts.sv */
// Checker of the core's bus, ready and sleep pins, bound to cxc_core.
// Assumes one clock domain and the asynchronous active-low reset of the core.
`timescale 1ns/1ps
`default_nettype none
module cxc_core_asserts (
  input wire logic i_core_clk, // Bus clock
  input wire logic i_arst_n, // Reset, active low
  input wire logic [7:0] i_data, // Data bus in
  input wire logic i_ready, // Resolved ready pin
  input wire logic i_irq_n, // Maskable request
  input wire logic i_nmi_n, // Non-maskable request
  input wire logic [15:0] o_addr, // Address bus
  input wire logic o_rwb, // 1 read, 0 write
  input wire logic [7:0] o_data, // Write data
  input wire logic o_data_oe_n, // Data drive enable
  input wire logic o_sync, // Opcode fetch
  input wire logic o_ready, // Ready drive value
  input wire logic o_ready_oe_n, // Ready drive enable
  input wire logic o_sleep_flag_active_low, // Low while asleep
  input wire logic o_sleep_flag_active_high // High while asleep
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  stall_hold_a: assert property (
    !i_ready && o_ready_oe_n |=> $stable(o_addr) && $stable(o_rwb) && $stable(o_data))
    else $error("Bus outputs moved during a ready stall");
  sleep_flags_a: assert property (
    o_sleep_flag_active_low != o_sleep_flag_active_high && o_ready_oe_n == o_sleep_flag_active_low)
    else $error("Wait flags and ready drive disagree");
  ready_pull_a: assert property (!o_ready_oe_n |-> !o_ready)
    else $error("Ready enabled but not pulled low");
  sleep_quiet_a: assert property (
    !o_sleep_flag_active_low && $past(!o_sleep_flag_active_low)
    |-> $stable(o_addr) && o_rwb && !o_sync)
    else $error("Bus active while asleep");
  wake_irq_a: assert property (
    !o_sleep_flag_active_low && !i_irq_n |-> ##1 (o_sleep_flag_active_low && o_sync))
    else $error("No wake and fetch one cycle after a request");
  sleep_entry_a: assert property (
    $fell(o_sleep_flag_active_low) |-> !o_ready_oe_n && $past(o_sync, 2) && $stable(o_addr))
    else $error("Sleep not entered two cycles after its fetch");
  one_write_a: assert property (
    !o_rwb && i_ready |=> o_rwb || o_addr != $past(o_addr))
    else $error("Two writes in a row at one address");
  sync_next_a: assert property (
    o_sync && i_ready |=> !o_sync || o_addr == $past(o_addr) + 16'h0001)
    else $error("Fetch after a one-cycle opcode not at the next address");

  // Main scenarios reached
  stall_write_c: cover property (!i_ready && !o_rwb);
  sleep_c: cover property ($fell(o_sleep_flag_active_low));
  short_op_c: cover property (o_sync ##1 o_sync);
endmodule : cxc_core_asserts

bind cxc_core cxc_core_asserts u_chk (.i_core_clk, .i_arst_n, .i_data, .i_ready, .i_irq_n,
  .i_nmi_n, .o_addr, .o_rwb, .o_data, .o_data_oe_n, .o_sync, .o_ready, .o_ready_oe_n,
  .o_sleep_flag_active_low, .o_sleep_flag_active_high);
`default_nettype wire

/* File: dv/cxc_core_test.sv */
// Self-checking bench: cxc_core runs one program out of cxc_mem.
// Assumes the core reads its start address at FFFC; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module cxc_core_test;
  import cxc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_rdy = 1'b1;
  logic irq_n = 1'b1;
  logic nmi_n = 1'b1;
  logic rdy_pin, rwb, doe_n, sync, rdy_o, rdy_oe_n, slp_l, slp_h;
  logic [7:0] rd, wd;
  logic [15:0] addr, pc;
  logic [16:0] tr [0:15];
  logic [15:0] ut [$];
  logic [7:0] prog [$];
  int err_count = 0;
  int n_checks = 0;

  // Clock, and the ready pin pulled low by whoever enables a drive
  always #20 clk = ~clk;
  assign rdy_pin = rdy_oe_n ? ext_rdy : rdy_o;

  cxc_core dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_data(rd), .i_ready(rdy_pin),
    .i_irq_n(irq_n), .i_nmi_n(nmi_n), .o_addr(addr), .o_rwb(rwb), .o_data(wd),
    .o_data_oe_n(doe_n), .o_sync(sync), .o_ready(rdy_o), .o_ready_oe_n(rdy_oe_n),
    .o_sleep_flag_active_low(slp_l), .o_sleep_flag_active_high(slp_h));
  cxc_mem mem (.i_core_clk(clk), .i_addr(addr), .i_rwb(rwb), .i_wdata(wd),
    .i_ready(rdy_pin), .o_rdata(rd));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic put(input logic [7:0] b);
    mem.m[pc] = b;
    pc = pc + 16'h0001;
  endtask : put

  // Program: undefined opcodes from a table {op, bytes, cycles}, then the test code
  task automatic load;
    for (int i = 0; i < 65536; i++) mem.m[i] = 8'h00;
    ut = {16'h0222, 16'h2222, 16'h4222, 16'h6222, 16'h8222, 16'hC222, 16'hE222,
           16'h4423, 16'h5424, 16'hD424, 16'hF424, 16'h5C38, 16'hDC34, 16'hFC34};
    for (int i = 0; i < 16; i++) ut.push_back({4'(i), 4'h3, 8'h11});
    for (int i = 0; i < 12; i++) ut.push_back({4'(i), 4'hB, 8'h11});
    ut.push_back(16'hEB11);
    ut.push_back(16'hFB11);
    pc = 16'h0200;
    foreach (ut[i]) begin
      put(ut[i][15:8]);
      repeat (ut[i][7:4] - 1) put(8'h00);
    end
    prog = {8'hA9, 8'h08, 8'h69, 8'h01, 8'hF8, 8'h69, 8'h01, 8'h8D, 8'h00, 8'h03,
             8'hBD, 8'h00, 8'h03, 8'hE8, 8'hBD, 8'hFF, 8'h02, 8'hFE, 8'h00, 8'h03,
             8'h6C, 8'hFF, 8'h02};
    foreach (prog[i]) put(prog[i]);
    prog = {8'h00, 8'hEE, 8'hCB, 8'h8D, 8'h00, 8'h03, 8'h58, 8'hAA};
    pc = 16'h1000;
    foreach (prog[i]) put(prog[i]);
    prog = {8'h00, 8'h12, 8'h00, 8'h02, 8'h00, 8'h11};
    pc = 16'hFFFA;
    foreach (prog[i]) put(prog[i]);
    mem.m[16'h1100] = 8'h40;
    mem.m[16'h1200] = 8'h69;
    mem.m[16'h1201] = 8'h01;
    mem.m[16'h1202] = 8'h40;
    mem.m[16'h0301] = 8'h7F;
    pc = 16'h0200;
  endtask : load

  // One instruction: trace each bus cycle up to the next fetch, check count and target
  task automatic step(input int cyc, input logic [15:0] nxt);
    int n;
    n = 0;
    do begin
      tr[n] = {rwb, addr};
      @(negedge clk);
      n++;
    end while (sync !== 1'b1 && n < 16);
    chk("cycles", n, cyc);
    chk("next fetch", addr, nxt);
    pc = nxt;
  endtask : step

  task automatic t_reset;
    repeat (16) @(negedge clk);
    chk("reset addr", addr, VEC_RST);
    chk("reset pins", {rwb, doe_n, sync, rdy_oe_n, slp_l, slp_h}, 6'b110110);
    rst_n = 1'b1;
    step(2, 16'h0200);
  endtask : t_reset

  task automatic t_undef;
    foreach (ut[i]) step(ut[i][3:0], pc + 16'(ut[i][7:4]));
  endtask : t_undef

  // Binary add after a load immediate, then a decimal add one cycle longer
  task automatic t_arith;
    step(2, pc + 16'h0002);
    step(2, pc + 16'h0002);
    step(2, pc + 16'h0001);
    step(3, pc + 16'h0002);
    step(4, pc + 16'h0003);
    chk("decimal sum", mem.m[16'h0300], 8'h10);
  endtask : t_arith

  task automatic t_index;
    logic [15:0] q;
    step(4, pc + 16'h0003);
    step(2, pc + 16'h0001);
    q = pc;
    step(5, pc + 16'h0003);
    chk("cross cycle", tr[3], {1'b1, q + 16'h0002});
    step(6, pc + 16'h0003);
    chk("rmw read 1", tr[3], {1'b1, 16'h0301});
    chk("rmw read 2", tr[4], {1'b1, 16'h0301});
    chk("rmw write", tr[5], {1'b0, 16'h0301});
    chk("rmw data", mem.m[16'h0301], 8'h80);
  endtask : t_index

  task automatic t_jump;
    step(6, 16'h1000);
    chk("ptr high", tr[5], {1'b1, 16'h0300});
  endtask : t_jump

  // NMI edge during the trap fetch: trap first, NMI at the handler's first fetch
  task automatic t_trap;
    nmi_n = 1'b0;
    step(7, 16'h1100);
    chk("pushed pch", mem.m[16'h01FD], 8'h10);
    chk("pushed pcl", mem.m[16'h01FC], 8'h02);
    chk("trap p bits", mem.m[16'h01FB] & 8'h18, 8'h18);
    nmi_n = 1'b1;
    step(7, 16'h1200);
    chk("nmi p bits", mem.m[16'h01F8] & 8'h18, 8'h00);
    step(2, 16'h1202);
    step(6, 16'h1100);
    step(6, 16'h1002);
  endtask : t_trap

  task automatic t_sleep;
    logic [15:0] a;
    int n;
    repeat (3) @(negedge clk);
    chk("sleep ready", {rdy_pin, rdy_oe_n}, 2'b00);
    chk("sleep flags", {slp_l, slp_h}, 2'b01);
    a = addr;
    repeat (6) @(negedge clk);
    chk("sleep hold", {addr, slp_l}, {a, 1'b0});
    irq_n = 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sync !== 1'b1 && n < 8);
    irq_n = 1'b1;
    chk("wake delay", n, 1);
    chk("wake fetch", {addr, slp_l, slp_h, rdy_oe_n}, {16'h1003, 3'b101});
  endtask : t_sleep

  // Ready held low in the write cycle of a store delays the write
  task automatic t_ready;
    int n;
    n = 0;
    while (rwb !== 1'b0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    ext_rdy = 1'b0;
    repeat (5) @(negedge clk);
    chk("stalled write", {rwb, addr, mem.m[16'h0300]}, {1'b0, 16'h0300, 8'h10});
    chk("write drive", {doe_n, wd}, {1'b0, 8'h11});
    ext_rdy = 1'b1;
    @(negedge clk);
    chk("written", mem.m[16'h0300], 8'h11);
    chk("after store", {sync, addr}, {1'b1, 16'h1006});
  endtask : t_ready

  // Request raised after interrupts are unmasked: taken at the next fetch, then returned to it
  task automatic t_irq;
    step(2, 16'h1007);
    irq_n = 1'b0;
    step(2, 16'h1008);
    irq_n = 1'b1;
    step(7, 16'h1100);
    chk("irq push", {mem.m[16'h01FD], mem.m[16'h01FC]}, 16'h1008);
    chk("irq p bits", mem.m[16'h01FB] & 8'h18, 8'h08);
    step(6, 16'h1008);
  endtask : t_irq

  initial begin
    load;
    t_reset;
    t_undef;
    t_arith;
    t_index;
    t_jump;
    t_trap;
    t_sleep;
    t_ready;
    t_irq;
    wrap_up;
  end

  // Watchdog: the program needs about two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    wrap_up;
  end
endmodule : cxc_core_test
`default_nettype wire

/* File: dv/cxc_mem.sv */
// Memory on the system bus: 64 KiB, reads answered in the same cycle.
// Assumes the bench loads the array before reset is released.
`timescale 1ns/1ps
`default_nettype none
module cxc_mem (
  input wire logic i_core_clk, // Bus clock
  input wire logic [15:0] i_addr, // Address bus
  input wire logic i_rwb, // 1 read, 0 write
  input wire logic [7:0] i_wdata, // Write data from the core
  input wire logic i_ready, // Resolved ready pin
  output logic [7:0] o_rdata // Read data to the core
);
  logic [7:0] m [0:65535];
  logic [7:0] last = 8'h00;
  // Outside reads the bus shows a value that flips each cycle, never stale data
  assign o_rdata = i_rwb ? m[i_addr] : ~last;
  // A write lands only at an edge with ready high, so a stalled write lands once
  always @(posedge i_core_clk) begin
    if (!i_rwb && i_ready) begin
      m[i_addr] <= i_wdata;
    end
    last <= o_rdata;
  end
endmodule : cxc_mem
`default_nettype wire

/* File: src/cxc_adder.sv */
// Add-with-carry unit, binary or packed decimal.
// N, Z and C come from the final result in both modes; V from the binary sum.
`timescale 1ns/1ps
`default_nettype none
module cxc_adder import cxc_pkg::*; (
  input wire logic [7:0] i_a, // Accumulator
  input wire logic [7:0] i_m, // Operand
  input wire logic i_c, // Carry in
  input wire logic i_dec, // Decimal mode
  output var cxc_alu_t o_res // Sum and flags
);
  logic [8:0] bin;
  logic [4:0] lo5;
  logic [4:0] hi5;

  // Decimal path adjusts each nibble by six past nine
  always_comb begin
    bin = {1'b0, i_a} + {1'b0, i_m} + {8'h00, i_c};
    lo5 = {1'b0, i_a[3:0]} + {1'b0, i_m[3:0]} + {4'h0, i_c};
    if (lo5 > 5'h09) lo5 = lo5 + 5'h06;
    hi5 = {1'b0, i_a[7:4]} + {1'b0, i_m[7:4]} + {4'h0, lo5[4]};
    if (hi5 > 5'h09) hi5 = hi5 + 5'h06;
    o_res.v = (i_a[7] == i_m[7]) && (bin[7] != i_a[7]);
    if (i_dec) begin
      o_res.sum = {hi5[3:0], lo5[3:0]};
      o_res.c = hi5[4];
    end else begin
      o_res.sum = bin[7:0];
      o_res.c = bin[8];
    end
    o_res.n = o_res.sum[7];
    o_res.z = (o_res.sum == 8'h00);
  end
endmodule : cxc_adder
`default_nettype wire

/* File: src/cxc_core.sv */
// Execution sequencer of an 8-bit core: bus cycles, traps, sleep, ready.
// Memory answers in the same cycle; data is sampled at the closing edge.
`timescale 1ns/1ps
`default_nettype none
module cxc_core import cxc_pkg::*; (
  input wire logic i_core_clk, // phase_two_clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [7:0] i_data, // Data bus in
  input wire logic i_ready, // Ready pin level
  input wire logic i_irq_n, // Maskable request, level
  input wire logic i_nmi_n, // Non-maskable, falling edge
  output logic [15:0] o_addr, // Address bus
  output logic o_rwb, // 1 read, 0 write
  output logic [7:0] o_data, // Data bus out
  output logic o_data_oe_n, // Low while driving data
  output logic o_sync, // Opcode fetch cycle
  output logic o_ready, // Ready pin drive value
  output logic o_ready_oe_n, // Low while pulling ready
  output logic o_sleep_flag_active_low, // Low while asleep
  output logic o_sleep_flag_active_high // High while asleep
);
  cxc_core_t s;
  cxc_core_t n;
  cxc_dec_t dec;
  cxc_alu_t alu;
  logic nmi_edge;
  logic [8:0] isum;
  logic [7:0] inc_v;

  cxc_decode u_decode (
    .i_op(i_data),
    .o_dec(dec)
  );

  cxc_adder u_adder (
    .i_a(s.a),
    .i_m(i_data),
    .i_c(s.p[P_C]),
    .i_dec(s.p[P_D]),
    .o_res(alu)
  );

  function automatic cxc_core_t rd(input cxc_core_t c, input logic [15:0] ad);
    rd = c;
    rd.addr = ad;
    rd.rwb = 1'b1;
    rd.doe_n = 1'b1;
  endfunction : rd

  function automatic cxc_core_t wr(input cxc_core_t c, input logic [15:0] ad,
                                   input logic [7:0] dt);
    wr = c;
    wr.addr = ad;
    wr.rwb = 1'b0;
    wr.dout = dt;
    wr.doe_n = 1'b0;
  endfunction : wr

  // Next opcode fetch; interrupts are only taken at this boundary
  function automatic cxc_core_t fetch(input cxc_core_t c, input logic irq_n);
    fetch = rd(c, c.pc);
    fetch.st = ST_FETCH;
    fetch.step = 4'h0;
    fetch.int_take = c.nmi_pend | (~irq_n & ~c.p[P_I]);
  endfunction : fetch

  // Effective access of the absolute group
  function automatic cxc_core_t access(input cxc_core_t c);
    if (c.cls == CL_STA) access = wr(c, {c.hi, c.lo}, c.a);
    else access = rd(c, {c.hi, c.lo});
    access.step = STEP_ACC;
  endfunction : access

  // Whole next state; a hold leaves n equal to s apart from the NMI edge tracking
  always_comb begin
    n = s;
    nmi_edge = s.nmi_prev & ~i_nmi_n;
    n.nmi_prev = i_nmi_n;
    n.nmi_pend = s.nmi_pend | nmi_edge; // Edge wins over a clear below
    isum = {1'b0, s.lo} + {1'b0, s.idx ? s.x : 8'h00};
    inc_v = s.tmp + 8'h01;
    unique case (s.st)
      ST_VEC: begin
        if (i_ready) begin
          if (s.step == 4'h0) begin
            n.lo = i_data;
            n = rd(n, VEC_RST + 16'h0001);
            n.step = 4'h1;
          end else begin
            n.pc = {i_data, s.lo};
            n = fetch(n, i_irq_n);
          end
        end
      end
      ST_SLEEP: begin
        // Wakes even with interrupts masked; then just carries on
        if (!i_irq_n || n.nmi_pend) begin
          n.rdy_oe_n = 1'b1;
          n.slp_n = 1'b1;
          n.slp = 1'b0;
          n = fetch(n, i_irq_n);
        end
      end
      ST_FETCH: begin
        if (i_ready) begin
          n.st = ST_EXEC;
          n.step = 4'h1;
          if (s.int_take) begin
            n.cls = CL_INT;
            n.vec = s.nmi_pend ? VEC_NMI : VEC_IRQ;
            if (s.nmi_pend) n.nmi_pend = nmi_edge;
            n = rd(n, s.pc);
          end else begin
            // A trap fetched here keeps its own vector whatever is pending
            n.op = i_data;
            n.cls = dec.cls;
            n.idx = dec.idx;
            n.bytes = dec.bytes;
            n.cycles = dec.cycles;
            n.vec = VEC_IRQ;
            n.pc = s.pc + 16'h0001;
            if (dec.cycles == 4'h1) n = fetch(n, i_irq_n);
            else n = rd(n, n.pc);
          end
        end
      end
      ST_EXEC: begin
        // External ready freezes every cycle kind, writes included
        if (i_ready) begin
          n.step = s.step + 4'h1;
          unique case (s.cls)
            CL_NOP: begin
              if (s.step < {2'b00, s.bytes}) n.pc = s.pc + 16'h0001;
              if (s.step + 4'h1 == s.cycles) n = fetch(n, i_irq_n);
              else if (s.step + 4'h1 < {2'b00, s.bytes}) n = rd(n, n.pc);
              else n = rd(n, s.addr);
            end
            CL_IMP: begin
              case (s.op)
                OP_CLD: n.p[P_D] = 1'b0;
                OP_SED: n.p[P_D] = 1'b1;
                OP_CLI: n.p[P_I] = 1'b0;
                OP_SEI: n.p[P_I] = 1'b1;
                OP_INX: begin
                  n.x = s.x + 8'h01;
                  n.p = set_nz(s.p, n.x);
                end
                OP_TAX: begin
                  n.x = s.a;
                  n.p = set_nz(s.p, s.a);
                end
                default: ;
              endcase
              n = fetch(n, i_irq_n);
            end
            CL_LDAI: begin
              n.a = i_data;
              n.p = set_nz(s.p, i_data);
              n.pc = s.pc + 16'h0001;
              n = fetch(n, i_irq_n);
            end
            CL_ADCI: begin
              if (s.step == 4'h1) begin
                n.a = alu.sum;
                n.p[P_N] = alu.n;
                n.p[P_V] = alu.v;
                n.p[P_Z] = alu.z;
                n.p[P_C] = alu.c;
                n.pc = s.pc + 16'h0001;
                // Decimal result costs one extra operand re-read
                if (s.p[P_D]) n = rd(n, s.addr);
                else n = fetch(n, i_irq_n);
              end else begin
                n = fetch(n, i_irq_n);
              end
            end
            CL_LDX, CL_STA, CL_RMW: begin
              unique case (s.step)
                4'h1: begin
                  n.lo = i_data;
                  n.pc = s.pc + 16'h0001;
                  n = rd(n, n.pc);
                end
                4'h2: begin
                  n.pc = s.pc + 16'h0001;
                  n.hi = i_data;
                  n.lo = isum[7:0];
                  if (isum[8]) n = rd(n, s.addr);
                  else n = access(n);
                end
                STEP_FIX: begin
                  n.hi = s.hi + 8'h01;
                  n = access(n);
                end
                STEP_ACC: begin
                  if (s.cls == CL_LDX) begin
                    n.a = i_data;
                    n.p = set_nz(s.p, i_data);
                    n = fetch(n, i_irq_n);
                  end else if (s.cls == CL_STA) begin
                    n = fetch(n, i_irq_n);
                  end else begin
                    n.tmp = i_data;
                    n = rd(n, s.addr);
                  end
                end
                4'h5: begin
                  n.p = set_nz(s.p, inc_v);
                  n = wr(n, s.addr, inc_v);
                end
                default: n = fetch(n, i_irq_n);
              endcase
            end
            CL_JMPI: begin
              unique case (s.step)
                4'h1: begin
                  n.lo = i_data;
                  n.pc = s.pc + 16'h0001;
                  n = rd(n, n.pc);
                end
                4'h2: begin
                  n.hi = i_data;
                  n = rd(n, {i_data, s.lo});
                end
                4'h3: begin
                  n.tmp = i_data;
                  // Full 16-bit increment; the carry costs a re-read cycle
                  if (s.lo == 8'hFF) begin
                    n = rd(n, s.addr);
                  end else begin
                    n = rd(n, {s.hi, s.lo} + 16'h0001);
                    n.step = 4'h5;
                  end
                end
                4'h4: n = rd(n, {s.hi, s.lo} + 16'h0001);
                default: begin
                  n.pc = {i_data, s.tmp};
                  n = fetch(n, i_irq_n);
                end
              endcase
            end
            CL_TRAP, CL_INT: begin
              unique case (s.step)
                4'h1: begin
                  if (s.cls == CL_TRAP) n.pc = s.pc + 16'h0001;
                  n = wr(n, stack_addr(s.sp), n.pc[15:8]);
                end
                4'h2: begin
                  n.sp = s.sp - 8'h01;
                  n = wr(n, stack_addr(n.sp), s.pc[7:0]);
                end
                4'h3: begin
                  n.sp = s.sp - 8'h01;
                  n = wr(n, stack_addr(n.sp),
                         {s.p[7:6], 1'b1, s.cls == CL_TRAP, s.p[3:0]});
                end
                4'h4: begin
                  n.sp = s.sp - 8'h01;
                  n.p[P_I] = 1'b1;
                  n.p[P_D] = 1'b0;
                  n = rd(n, s.vec);
                end
                4'h5: begin
                  n.lo = i_data;
                  n = rd(n, s.vec + 16'h0001);
                end
                default: begin
                  n.pc = {i_data, s.lo};
                  n = fetch(n, i_irq_n);
                end
              endcase
            end
            CL_RTI: begin
              unique case (s.step)
                4'h1: n = rd(n, stack_addr(s.sp));
                4'h2: begin
                  n.sp = s.sp + 8'h01;
                  n = rd(n, stack_addr(n.sp));
                end
                4'h3: begin
                  n.p = i_data | P_KEEP;
                  n.sp = s.sp + 8'h01;
                  n = rd(n, stack_addr(n.sp));
                end
                4'h4: begin
                  n.lo = i_data;
                  n.sp = s.sp + 8'h01;
                  n = rd(n, stack_addr(n.sp));
                end
                default: begin
                  n.pc = {i_data, s.lo};
                  n = fetch(n, i_irq_n);
                end
              endcase
            end
            CL_SLEEP: begin
              // Address stays put while asleep
              n.st = ST_SLEEP;
              n.rdy_oe_n = 1'b0;
              n.slp_n = 1'b0;
              n.slp = 1'b1;
            end
            default: n = fetch(n, i_irq_n);
          endcase
        end
      end
    endcase
  end

  // Reset starts the vector read with binary mode selected
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) s <= CORE_RST;
    else s <= n;
  end

  assign o_addr = s.addr;
  assign o_rwb = s.rwb;
  assign o_data = s.dout;
  assign o_data_oe_n = s.doe_n;
  assign o_sync = (s.st == ST_FETCH);
  assign o_ready = s.rdy_oe_n; // Only ever enabled while low
  assign o_ready_oe_n = s.rdy_oe_n;
  assign o_sleep_flag_active_low = s.slp_n;
  assign o_sleep_flag_active_high = s.slp;
endmodule : cxc_core
`default_nettype wire

/* File: src/cxc_decode.sv */
// Opcode classifier: class, length and cycle count of a fetched opcode.
// Purely combinational; the core samples it only in the fetch cycle.
`timescale 1ns/1ps
`default_nettype none
module cxc_decode import cxc_pkg::*; (
  input wire logic [7:0] i_op, // Opcode on the data bus
  output var cxc_dec_t o_dec // Decoded class and timing
);
  // Undefined codes by low nibble first, then the other undefined codes and the supported subset
  always_comb begin
    o_dec = '{CL_IMP, 1'b0, 2'h1, 4'h2};
    if (i_op[3:0] == 4'h3 || (i_op[3:0] == 4'hB && i_op != OP_SLEEP &&
        i_op != OP_STOP)) begin
      o_dec = DEC_U11;
    end else if (i_op[3:0] == 4'h2 && !i_op[4] && i_op != 8'hA2) begin
      o_dec = DEC_U22;
    end
    case (i_op)
      8'h44: o_dec = DEC_U23;
      8'h54, 8'hD4, 8'hF4: o_dec = DEC_U24;
      8'h5C: o_dec = DEC_U38;
      8'hDC, 8'hFC: o_dec = DEC_U34;
      OP_TRAP: o_dec.cls = CL_TRAP;
      OP_RTI: o_dec.cls = CL_RTI;
      OP_SLEEP: o_dec.cls = CL_SLEEP;
      OP_JMPI: o_dec.cls = CL_JMPI;
      OP_LDAI: o_dec.cls = CL_LDAI;
      OP_ADCI: o_dec.cls = CL_ADCI;
      OP_LDAX: o_dec = '{CL_LDX, 1'b1, 2'h3, 4'h4};
      OP_STA: o_dec = '{CL_STA, 1'b0, 2'h3, 4'h4};
      OP_INC: o_dec = '{CL_RMW, 1'b0, 2'h3, 4'h6};
      OP_INCX: o_dec = '{CL_RMW, 1'b1, 2'h3, 4'h6};
      default: ;
    endcase
  end
endmodule : cxc_decode
`default_nettype wire

/* File: src/cxc_pkg.sv */
// Shared constants, types and helpers of the execution core.
// Assumes a single clock; each clock edge ends one bus cycle.
package cxc_pkg;
  // Vectors and stack
  localparam logic [15:0] VEC_NMI = 16'hFFFA;
  localparam logic [15:0] VEC_RST = 16'hFFFC;
  localparam logic [15:0] VEC_IRQ = 16'hFFFE;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] SP_RST = 8'hFD;
  // Status bit positions and fixed values
  localparam int P_N = 7;
  localparam int P_V = 6;
  localparam int P_B = 4;
  localparam int P_D = 3;
  localparam int P_I = 2;
  localparam int P_Z = 1;
  localparam int P_C = 0;
  localparam logic [7:0] P_RST = 8'h34;
  localparam logic [7:0] P_KEEP = 8'h30;
  // Step numbers of the absolute sequence
  localparam logic [3:0] STEP_FIX = 4'h3;
  localparam logic [3:0] STEP_ACC = 4'h4;
  // Supported opcodes
  localparam logic [7:0] OP_TRAP = 8'h00;
  localparam logic [7:0] OP_RTI = 8'h40;
  localparam logic [7:0] OP_SLEEP = 8'hCB;
  localparam logic [7:0] OP_JMPI = 8'h6C;
  localparam logic [7:0] OP_LDAI = 8'hA9;
  localparam logic [7:0] OP_ADCI = 8'h69;
  localparam logic [7:0] OP_LDAX = 8'hBD;
  localparam logic [7:0] OP_STA = 8'h8D;
  localparam logic [7:0] OP_INC = 8'hEE;
  localparam logic [7:0] OP_INCX = 8'hFE;
  localparam logic [7:0] OP_CLD = 8'hD8;
  localparam logic [7:0] OP_SED = 8'hF8;
  localparam logic [7:0] OP_CLI = 8'h58;
  localparam logic [7:0] OP_SEI = 8'h78;
  localparam logic [7:0] OP_INX = 8'hE8;
  localparam logic [7:0] OP_TAX = 8'hAA;
  localparam logic [7:0] OP_STOP = 8'hDB;

  typedef enum logic [3:0] {
    ST_VEC = 4'h1, ST_FETCH = 4'h2, ST_EXEC = 4'h4, ST_SLEEP = 4'h8
  } cxc_state_t;

  typedef enum logic [3:0] {
    CL_NOP, CL_IMP, CL_LDAI, CL_ADCI, CL_LDX, CL_STA, CL_RMW,
    CL_JMPI, CL_TRAP, CL_INT, CL_RTI, CL_SLEEP
  } cxc_class_t;

  typedef struct packed {
    cxc_class_t cls;
    logic idx;
    logic [1:0] bytes;
    logic [3:0] cycles;
  } cxc_dec_t;

  // Undefined opcode timings: bytes and cycles
  localparam cxc_dec_t DEC_U11 = '{CL_NOP, 1'b0, 2'h1, 4'h1};
  localparam cxc_dec_t DEC_U22 = '{CL_NOP, 1'b0, 2'h2, 4'h2};
  localparam cxc_dec_t DEC_U23 = '{CL_NOP, 1'b0, 2'h2, 4'h3};
  localparam cxc_dec_t DEC_U24 = '{CL_NOP, 1'b0, 2'h2, 4'h4};
  localparam cxc_dec_t DEC_U38 = '{CL_NOP, 1'b0, 2'h3, 4'h8};
  localparam cxc_dec_t DEC_U34 = '{CL_NOP, 1'b0, 2'h3, 4'h4};

  typedef struct packed {
    logic [7:0] sum;
    logic n, v, z, c;
  } cxc_alu_t;

  typedef struct packed {
    cxc_state_t st;
    logic [3:0] step;
    cxc_class_t cls;
    logic idx;
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic [7:0] op;
    logic [15:0] pc, addr, vec;
    logic rwb;
    logic [7:0] dout;
    logic doe_n;
    logic [7:0] a, x, sp, p, lo, hi, tmp;
    logic int_take, nmi_prev, nmi_pend, rdy_oe_n, slp_n, slp;
  } cxc_core_t;

  localparam cxc_core_t CORE_RST = '{st: ST_VEC, cls: CL_NOP, addr: VEC_RST,
    rwb: 1'b1, doe_n: 1'b1, sp: SP_RST, p: P_RST, nmi_prev: 1'b1,
    rdy_oe_n: 1'b1, slp_n: 1'b1, default: '0};

  function automatic logic [15:0] stack_addr(input logic [7:0] sp);
    stack_addr = {STACK_PAGE, sp};
  endfunction : stack_addr

  function automatic logic [7:0] set_nz(input logic [7:0] p, input logic [7:0] v);
    set_nz = p;
    set_nz[P_N] = v[7];
    set_nz[P_Z] = (v == 8'h00);
  endfunction : set_nz
endpackage : cxc_pkg
